// ---- pkg/fbpes_pkg.sv ----
// Constants, command codes and shared types of the flash sequencer host
// ---------------------------------------------------------------------
// How it works
// R1 - Device ignores commands while programming, except suspend
// R2 - No secure, ident or query access while programming
// R3 - Reset pin aborts programming; restart afterwards
// R4 - Same address may be programmed repeatedly
// R5 - Write buffer holds sixteen words, one operation
// R6 - Two unlocks then buffer load at sector
// R7 - Then write word count minus one at sector
// R8 - Count beyond buffer size aborts the operation
// R9 - Loads outside first page abort the operation
// R10 - Loads outside the load sector abort
// R11 - Counter drops each load; last data wins
// R12 - Confirm at sector after loads, else abort
// R13 - Abort shows abort flag set, error clear, toggling
// R14 - Buffer program suspendable; completes into read mode (host only ever suspends sector erase)
// R15 - Sector erase: unlock, setup, unlock, erase command
// R16 - Sector erase accepts only suspend; one sector each
// R17 - Erase end returns to read, status bits report
// R18 - Chip erase preprograms, then erases to ones
// R19 - Chip erase ignores commands; reset still aborts
// R20 - Erase suspend works only during sector erase
// R21 - Suspend completes within twenty microseconds
// R22 - Suspended: other sectors usable, status on low byte
// R23 - Polling bit inverted while programming, true after
// R24 - Keep sector, page and count; compare loads
// ---------------------------------------------------------------------
package fbpes_pkg;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_AS_NS = 10;
   localparam int T_WP_NS = 35;
   localparam int T_WPH_NS = 20;
   localparam int T_ACC_NS = 70;
   localparam int T_RP_NS = 500;
   localparam int T_RH_NS = 200;
   localparam int T_SUSP_US = 20;
   localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSP_CYC = (T_SUSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] AS_CNT = 12'(AS_CYC);
   localparam logic [11:0] WP_CNT = 12'(WP_CYC);
   localparam logic [11:0] WPH_CNT = 12'(WPH_CYC);
   localparam logic [11:0] ACC_CNT = 12'(ACC_CYC);
   localparam logic [11:0] RP_CNT = 12'(RP_CYC);
   localparam logic [11:0] RH_CNT = 12'(RH_CYC);
   localparam logic [11:0] SUSP_CNT = 12'(SUSP_CYC);

   // ---------------------------------------------------------------------
   // Address layout and status bit positions
   // ---------------------------------------------------------------------
   localparam int SECT_LSB = 15;
   localparam int PAGE_LSB = 4;
   localparam logic [4:0] BUF_WORDS = 5'h10;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int ERR_BIT = 5;
   localparam int TOGGLE2_BIT = 2;
   localparam int ABORT_BIT = 1;

   // ---------------------------------------------------------------------
   // Command cycles
   // ---------------------------------------------------------------------
   localparam logic [21:0] UNLOCK_A1 = 22'h000555;
   localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
   localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_D2 = 16'h0055;
   localparam logic [15:0] CMD_PROG = 16'h00a0;
   localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
   localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_SECT_ERASE = 16'h0030;
   localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
   localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] CMD_RESET = 16'h00f0;

   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_PROG = 4'h1,
      OP_BUF = 4'h2,
      OP_SERASE = 4'h3,
      OP_CERASE = 4'h4,
      OP_SUSPEND = 4'h5,
      OP_RESUME = 4'h6,
      OP_RESET = 4'h7,
      OP_HWRESET = 4'h8
   } fbpes_op_t;

   typedef enum logic [1:0] {
      RSP_OK = 2'h0,
      RSP_ABORT = 2'h1,
      RSP_ERROR = 2'h2,
      RSP_REFUSED = 2'h3
   } fbpes_rsp_t;

endpackage

// ---- src/fbpes_bus.sv ----
// Single asynchronous flash bus cycle: strobe timing for one read or write
`timescale 1ns/1ps
module fbpes_bus
   import fbpes_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic req,
   input wire logic req_wr,
   input wire logic [21:0] req_addr,
   input wire logic [15:0] req_data,
   output logic done,
   output logic [15:0] rdata,
   output logic [21:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_we_n,
   output logic fl_oe_n
);
   import fbpes_pkg::*;

   typedef enum logic [1:0] {
      B_IDLE = 2'b00,
      B_SETUP = 2'b01,
      B_STROBE = 2'b10,
      B_HOLD = 2'b11
   } fbpes_phase_t;

   typedef struct packed {
      fbpes_phase_t phase;
      logic wr;
      logic [11:0] cnt;
      logic done;
      logic [15:0] rdata;
      logic [21:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
      logic ce_n;
      logic we_n;
      logic oe_n;
   } fbpes_bus_t;

   fbpes_bus_t r_reg, r_next;

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      case (r_reg.phase)
         B_IDLE: begin
            if (req) begin
               r_next.addr = req_addr;
               r_next.dq_out = req_data;
               r_next.wr = req_wr;
               r_next.dq_oe = req_wr;
               r_next.ce_n = 1'b0;
               r_next.cnt = AS_CNT;
               r_next.phase = B_SETUP;
            end
         end
         B_SETUP: begin
            if (r_reg.cnt > 12'h001) begin
               r_next.cnt = r_reg.cnt - 12'h001;
            end else begin
               r_next.we_n = ~r_reg.wr;
               r_next.oe_n = r_reg.wr;
               r_next.cnt = r_reg.wr ? WP_CNT : ACC_CNT;
               r_next.phase = B_STROBE;
            end
         end
         B_STROBE: begin
            if (r_reg.cnt > 12'h001) begin
               r_next.cnt = r_reg.cnt - 12'h001;
            end else begin
               // Sampled before OE rises, after full access time
               if (!r_reg.wr) begin
                  r_next.rdata = fl_dq_in;
               end
               r_next.we_n = 1'b1;
               r_next.oe_n = 1'b1;
               r_next.cnt = WPH_CNT;
               r_next.phase = B_HOLD;
            end
         end
         default: begin
            if (r_reg.cnt > 12'h001) begin
               r_next.cnt = r_reg.cnt - 12'h001;
            end else begin
               // CE and OE both rise between reads, so toggle bits advance
               r_next.ce_n = 1'b1;
               r_next.dq_oe = 1'b0;
               r_next.done = 1'b1;
               r_next.phase = B_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r_reg <= '{phase: B_IDLE, wr: 1'b0, cnt: 12'h000, done: 1'b0, rdata: 16'h0000,
                    addr: 22'h000000, dq_out: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1,
                    we_n: 1'b1, oe_n: 1'b1};
      end else begin
         r_reg <= r_next;
      end
   end

   assign done = r_reg.done;
   assign rdata = r_reg.rdata;
   assign fl_addr = r_reg.addr;
   assign fl_dq_out = r_reg.dq_out;
   assign fl_dq_oe = r_reg.dq_oe;
   assign fl_ce_n = r_reg.ce_n;
   assign fl_we_n = r_reg.we_n;
   assign fl_oe_n = r_reg.oe_n;
endmodule

// ---- src/fbpes_ctrl.sv ----
// Host sequencer: program, buffer program, erase, suspend and reset of a NOR flash
`timescale 1ns/1ps
module fbpes_ctrl
   import fbpes_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire fbpes_pkg::fbpes_op_t cmd_op,
   input wire logic [21:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   input wire logic [4:0] cmd_count,
   input wire logic ld_valid,
   output logic ld_ready,
   input wire logic [3:0] ld_offset,
   input wire logic [15:0] ld_data,
   output logic rsp_valid,
   output fbpes_pkg::fbpes_rsp_t rsp_status,
   output logic [15:0] rsp_data,
   output logic busy,
   output logic suspended,
   output logic [21:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_we_n,
   output logic fl_oe_n,
   output logic fl_reset_n
);
   import fbpes_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_HDR = 3'b001,
      S_LOAD = 3'b010,
      S_POLL = 3'b011,
      S_WAIT = 3'b100,
      S_HWRST = 3'b101,
      S_FINISH = 3'b110,
      S_CONF = 3'b111
   } fbpes_state_t;

   typedef struct packed {
      logic last;
      logic wr;
      logic [21:0] a;
      logic [15:0] d;
   } fbpes_cyc_t;

   typedef struct packed {
      fbpes_state_t st;
      fbpes_op_t op;
      logic [2:0] step;
      logic [21:0] sa;
      logic [21:0] addr;
      logic [15:0] data;
      logic [4:0] cnt;
      logic pend;
      logic bus_req;
      logic bus_wr;
      logic [21:0] bus_addr;
      logic [15:0] bus_data;
      logic have_prev;
      logic [15:0] prev;
      logic [11:0] wait_cnt;
      logic hw_high;
      fbpes_rsp_t res;
      logic rst_n;
      logic cmd_ready;
      logic ld_ready;
      logic rsp_valid;
      fbpes_rsp_t rsp_status;
      logic [15:0] rsp_data;
      logic busy;
      logic suspended;
   } fbpes_ctl_t;

   fbpes_ctl_t r_reg, r_next;
   logic bus_done;
   logic [15:0] bus_rdata;
   fbpes_cyc_t cyc;

   // ---------------------------------------------------------------------
   // Command cycle tables
   // ---------------------------------------------------------------------
   function automatic fbpes_cyc_t hdr_cycle(input fbpes_op_t op, input logic [2:0] k,
                                            input logic [21:0] sa, input logic [21:0] a,
                                            input logic [15:0] d, input logic [4:0] n);
      fbpes_cyc_t c;
      c = '{last: 1'b0, wr: 1'b1, a: UNLOCK_A1, d: UNLOCK_D1};
      if (k == 3'd1 || k == 3'd4) begin
         c.a = UNLOCK_A2;
         c.d = UNLOCK_D2;
      end
      case (op)
         OP_PROG: begin
            if (k == 3'd2) begin
               c.d = CMD_PROG;
            end else if (k == 3'd3) begin
               c = '{last: 1'b1, wr: 1'b1, a: a, d: d}; // [R4]
            end
         end
         OP_BUF: begin
            if (k == 3'd2) begin
               c.a = sa; // [R6]
               c.d = CMD_BUF_LOAD;
            end else if (k == 3'd3) begin
               c = '{last: 1'b1, wr: 1'b1, a: sa, d: {11'h000, n - 5'd1}}; // [R7]
            end
         end
         OP_SERASE, OP_CERASE: begin
            if (k == 3'd2) begin
               c.d = CMD_ERASE_SETUP; // [R15]
            end else if (k == 3'd5) begin
               c.last = 1'b1;
               c.a = (op == OP_SERASE) ? sa : UNLOCK_A1; // [R16]
               c.d = (op == OP_SERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE; // [R18]
            end
         end
         OP_RESET: begin
            if (k == 3'd2) begin
               c.d = CMD_RESET;
               c.last = 1'b1;
            end
         end
         OP_SUSPEND: c = '{last: 1'b1, wr: 1'b1, a: sa, d: CMD_SUSPEND};
         OP_RESUME: c = '{last: 1'b1, wr: 1'b1, a: sa, d: CMD_RESUME};
         default: c = '{last: 1'b1, wr: 1'b0, a: a, d: 16'h0000};
      endcase
      return c;
   endfunction

   // ---------------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.bus_req = 1'b0;
      r_next.rsp_valid = 1'b0;
      cyc = hdr_cycle(r_reg.op, r_reg.step, r_reg.sa, r_reg.addr, r_reg.data, r_reg.cnt);
      case (r_reg.st)
         S_IDLE: begin
            if (cmd_valid && r_reg.cmd_ready) begin
               if (cmd_op == OP_HWRESET) begin
                  r_next.rst_n = 1'b0; // [R3] [R19]
                  r_next.hw_high = 1'b0;
                  r_next.wait_cnt = RP_CNT;
                  r_next.cmd_ready = 1'b0;
                  r_next.busy = 1'b1;
                  r_next.st = S_HWRST;
               end else if ((cmd_op == OP_BUF && (cmd_count == 5'd0 || cmd_count > BUF_WORDS))
                            || (cmd_op == OP_SUSPEND)
                            || (cmd_op == OP_RESUME && !r_reg.suspended)
                            || ((cmd_op == OP_SERASE || cmd_op == OP_CERASE || cmd_op == OP_BUF)
                                && r_reg.suspended)
                            || cmd_op > OP_HWRESET) begin
                  // Refused here rather than letting the device abort [R8] [R20] [R5]
                  r_next.rsp_valid = 1'b1;
                  r_next.rsp_status = RSP_REFUSED;
               end else begin
                  r_next.op = cmd_op;
                  r_next.addr = cmd_addr;
                  r_next.data = cmd_data;
                  r_next.cnt = cmd_count;
                  r_next.sa = (cmd_op == OP_RESUME) ? r_reg.sa
                              : {cmd_addr[21:SECT_LSB], 15'h0000}; // [R24]
                  r_next.step = 3'd0;
                  r_next.res = RSP_OK;
                  r_next.cmd_ready = 1'b0;
                  r_next.busy = 1'b1;
                  r_next.st = S_HDR;
               end
            end
         end
         S_HDR: begin
            if (!r_reg.pend) begin
               r_next.bus_req = 1'b1;
               r_next.bus_wr = cyc.wr;
               r_next.bus_addr = cyc.a;
               r_next.bus_data = cyc.d;
               r_next.pend = 1'b1;
            end else if (bus_done) begin
               r_next.pend = 1'b0;
               r_next.step = r_reg.step + 3'd1;
               if (cyc.last) begin
                  r_next.have_prev = 1'b0;
                  case (r_reg.op)
                     OP_READ: begin
                        // Inside a suspended sector this is status on the low byte [R22]
                        r_next.rsp_data = bus_rdata;
                        r_next.st = S_FINISH;
                     end
                     OP_BUF: begin
                        r_next.ld_ready = 1'b1;
                        r_next.st = S_LOAD;
                     end
                     OP_SUSPEND: begin
                        r_next.wait_cnt = SUSP_CNT; // [R21]
                        r_next.st = S_WAIT;
                     end
                     OP_RESUME: begin
                        r_next.suspended = 1'b0;
                        r_next.op = OP_SERASE;
                        r_next.addr = r_reg.sa;
                        r_next.st = S_POLL;
                     end
                     OP_RESET: r_next.st = S_FINISH;
                     OP_SERASE: begin
                        r_next.addr = r_reg.sa;
                        r_next.cmd_ready = 1'b1;
                        r_next.st = S_POLL;
                     end
                     default: r_next.st = S_POLL;
                  endcase
               end
            end
         end
         S_LOAD: begin
            if (ld_valid && r_reg.ld_ready) begin
               // Offset only within the latched page, so page and sector cannot drift [R9] [R10]
               r_next.addr = {r_reg.addr[21:PAGE_LSB], ld_offset};
               r_next.bus_req = 1'b1;
               r_next.bus_wr = 1'b1;
               r_next.bus_addr = {r_reg.addr[21:PAGE_LSB], ld_offset};
               r_next.bus_data = ld_data;
               r_next.ld_ready = 1'b0;
               r_next.pend = 1'b1;
            end else if (r_reg.pend && bus_done) begin
               r_next.pend = 1'b0;
               r_next.cnt = r_reg.cnt - 5'd1; // [R11]
               if (r_reg.cnt == 5'd1) begin
                  r_next.st = S_CONF;
               end else begin
                  r_next.ld_ready = 1'b1;
               end
            end
         end
         S_CONF: begin
            if (!r_reg.pend) begin
               r_next.bus_req = 1'b1;
               r_next.bus_wr = 1'b1;
               r_next.bus_addr = r_reg.sa;
               r_next.bus_data = CMD_BUF_CONFIRM; // [R12]
               r_next.pend = 1'b1;
            end else if (bus_done) begin
               r_next.pend = 1'b0;
               r_next.st = S_POLL; // [R14]
            end
         end
         S_POLL: begin
            r_next.cmd_ready = 1'b0;
            if (r_reg.op == OP_SERASE && cmd_valid && r_reg.cmd_ready && !r_reg.pend) begin
               if (cmd_op == OP_SUSPEND) begin
                  r_next.op = OP_SUSPEND; // [R20]
                  r_next.step = 3'd0;
                  r_next.st = S_HDR;
               end else begin
                  r_next.rsp_valid = 1'b1; // [R16]
                  r_next.rsp_status = RSP_REFUSED;
               end
            end else if (!r_reg.pend) begin
               r_next.bus_req = 1'b1;
               r_next.bus_wr = 1'b0;
               r_next.bus_addr = r_reg.addr;
               r_next.pend = 1'b1;
            end else if (bus_done) begin
               r_next.pend = 1'b0;
               r_next.cmd_ready = (r_reg.op == OP_SERASE);
               r_next.prev = bus_rdata;
               r_next.have_prev = 1'b1;
               if (r_reg.have_prev) begin
                  if (r_reg.prev[TOGGLE_BIT] == bus_rdata[TOGGLE_BIT]) begin
                     // Toggle stopped: back in read mode [R17]
                     r_next.rsp_data = bus_rdata;
                     r_next.cmd_ready = 1'b0;
                     if (r_reg.op == OP_PROG && bus_rdata[POLL_BIT] != r_reg.data[POLL_BIT]) begin
                        r_next.res = RSP_ERROR; // [R23]
                     end
                     r_next.st = S_FINISH;
                  end else if (r_reg.prev[ABORT_BIT] && !r_reg.prev[ERR_BIT]) begin
                     // Abort state needs the reset sequence to leave [R13]
                     r_next.res = RSP_ABORT;
                     r_next.op = OP_RESET;
                     r_next.step = 3'd0;
                     r_next.cmd_ready = 1'b0;
                     r_next.st = S_HDR;
                  end else if (r_reg.prev[ERR_BIT]) begin
                     r_next.res = RSP_ERROR;
                     r_next.op = OP_RESET;
                     r_next.step = 3'd0;
                     r_next.cmd_ready = 1'b0;
                     r_next.st = S_HDR;
                  end
               end
            end
         end
         S_WAIT: begin
            if (r_reg.wait_cnt > 12'h001) begin
               r_next.wait_cnt = r_reg.wait_cnt - 12'h001;
            end else begin
               r_next.suspended = 1'b1; // [R22]
               r_next.st = S_FINISH;
            end
         end
         S_HWRST: begin
            if (r_reg.wait_cnt > 12'h001) begin
               r_next.wait_cnt = r_reg.wait_cnt - 12'h001;
            end else if (!r_reg.hw_high) begin
               r_next.rst_n = 1'b1;
               r_next.hw_high = 1'b1;
               r_next.wait_cnt = RH_CNT;
            end else begin
               r_next.suspended = 1'b0;
               r_next.res = RSP_OK;
               r_next.st = S_FINISH;
            end
         end
         default: begin
            r_next.rsp_valid = 1'b1;
            r_next.rsp_status = r_reg.res;
            r_next.busy = 1'b0;
            r_next.cmd_ready = 1'b1;
            r_next.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r_reg <= '{st: S_IDLE, op: OP_READ, step: 3'd0, sa: 22'h000000, addr: 22'h000000,
                    data: 16'h0000, cnt: 5'd0, pend: 1'b0, bus_req: 1'b0, bus_wr: 1'b0,
                    bus_addr: 22'h000000, bus_data: 16'h0000, have_prev: 1'b0,
                    prev: 16'h0000, wait_cnt: 12'h000, hw_high: 1'b0, res: RSP_OK,
                    rst_n: 1'b1, cmd_ready: 1'b1, ld_ready: 1'b0, rsp_valid: 1'b0,
                    rsp_status: RSP_OK, rsp_data: 16'h0000, busy: 1'b0, suspended: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   fbpes_bus u_bus (
      .mclk(mclk),
      .rst(rst),
      .req(r_reg.bus_req),
      .req_wr(r_reg.bus_wr),
      .req_addr(r_reg.bus_addr),
      .req_data(r_reg.bus_data),
      .done(bus_done),
      .rdata(bus_rdata),
      .fl_addr(fl_addr),
      .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in),
      .fl_ce_n(fl_ce_n),
      .fl_we_n(fl_we_n),
      .fl_oe_n(fl_oe_n)
   );

   assign cmd_ready = r_reg.cmd_ready;
   assign ld_ready = r_reg.ld_ready;
   assign rsp_valid = r_reg.rsp_valid;
   assign rsp_status = r_reg.rsp_status;
   assign rsp_data = r_reg.rsp_data;
   assign busy = r_reg.busy;
   assign suspended = r_reg.suspended;
   assign fl_reset_n = r_reg.rst_n;
endmodule

// ---- tb/fbpes_flash_model.sv ----
// Behavioural NOR flash answering the host sequencer's bus cycles
`timescale 1ns/1ps
module fbpes_flash_model (
   input wire logic [21:0] fl_addr,
   input wire logic [15:0] fl_dq_out,
   output logic [15:0] fl_dq_in,
   input wire logic fl_ce_n,
   input wire logic fl_we_n,
   input wire logic fl_oe_n,
   input wire logic fl_reset_n
);
   logic [15:0] mem [0:63];
   logic [15:0] q, pd = 16'h0000;
   logic pg = 0, er = 0, sus = 0, tg = 0;
   logic [1:0] bs = 2'h0;
   int bsy = 0, n = 0;
   initial for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
   // Status on the low byte while busy
   assign q = bsy > 0 ? {8'h00, er ? sus : ~pd[7], tg & !sus, 6'h00} : mem[fl_addr[5:0]];
   // Released bus shows the inverse, never a stale match
   assign fl_dq_in = (fl_oe_n || fl_ce_n) ? ~q : q;
   always @(posedge fl_we_n) begin
      if (fl_ce_n || !fl_reset_n) begin
      end else if (bsy > 0) begin
         if (er && fl_dq_out == 16'h00b0) sus = 1;
         else if (sus && fl_dq_out == 16'h0030) sus = 0;
      end else if (pg || (bs == 2'h2 && n > 0)) begin
         mem[fl_addr[5:0]] = mem[fl_addr[5:0]] & fl_dq_out;
         pd = fl_dq_out;
         n = n - 1;
         if (pg) bsy = 3;
         pg = 0;
      end else if (bs == 2'h1) begin
         n = int'(fl_dq_out) + 1;
         bs = 2'h2;
      end else if (bs == 2'h2) begin
         bs = 2'h0;
         bsy = 3;
      end else if (fl_dq_out == 16'h00a0) pg = 1;
      else if (fl_dq_out == 16'h0025) bs = 2'h1;
      else if (fl_dq_out == 16'h0030 || fl_dq_out == 16'h0010) begin
         for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
         er = fl_dq_out == 16'h0030;
         bsy = 40;
      end
   end
   always @(negedge fl_oe_n) if (bsy > 0 && !sus) begin
      tg = ~tg;
      bsy = bsy - 1;
   end
   always @(negedge fl_reset_n) begin
      bsy = 0;
      sus = 0;
      pg = 0;
      bs = 2'h0;
   end
endmodule

// ---- tb/fbpes_ctrl_chk.sv ----
// Port checker for the flash sequencer host
`timescale 1ns/1ps
module fbpes_ctrl_chk
   import fbpes_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire fbpes_pkg::fbpes_op_t cmd_op,
   input wire logic [4:0] cmd_count,
   input wire logic rsp_valid,
   input wire fbpes_pkg::fbpes_rsp_t rsp_status,
   input wire logic busy,
   input wire logic suspended,
   input wire logic fl_ce_n,
   input wire logic fl_we_n,
   input wire logic fl_oe_n,
   input wire logic fl_reset_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire take = cmd_valid && cmd_ready;
   sequence s_we;
      !fl_we_n [*2] ##1 fl_we_n;
   endsequence
   sequence s_ref;
      rsp_valid && rsp_status == RSP_REFUSED;
   endsequence
   sequence s_rlow;
      !fl_reset_n [*8];
   endsequence
   AST_STROBES: assert property (fl_we_n || fl_oe_n) else $error("we and oe low");
   AST_WE_CE: assert property (!fl_we_n |-> !fl_ce_n) else $error("we without ce");
   AST_WE_LEN: assert property ($fell(fl_we_n) |-> s_we) else $error("we width");
   AST_BUF_CNT: assert property (take && cmd_op == OP_BUF
      && (cmd_count == 5'h00 || cmd_count > BUF_WORDS) |=> s_ref) else $error("bad count");
   AST_SUSP: assert property (take && cmd_op == OP_SUSPEND && !busy && !suspended
      |=> s_ref) else $error("idle suspend");
   AST_HWRST: assert property (take && cmd_op == OP_HWRESET && !busy
      |-> ##[1:4] s_rlow) else $error("reset pulse");
   AST_ONE: assert property (take |=> !cmd_ready || rsp_valid) else $error("ready held");
   AST_RST_CE: assert property (!fl_reset_n |-> fl_ce_n) else $error("ce in reset");
endmodule
bind fbpes_ctrl fbpes_ctrl_chk CHK (.*);

// ---- tb/fbpes_ctrl_test.sv ----
// Self-checking bench for the flash sequencer host
`timescale 1ns/1ps
module fbpes_ctrl_test;
   import fbpes_pkg::*;
   logic mclk = 0, rst = 1, cmd_valid = 0, ld_valid = 0;
   fbpes_op_t cmd_op = OP_READ;
   fbpes_rsp_t rsp_status;
   logic [21:0] cmd_addr = 22'h000000, fl_addr;
   logic [15:0] cmd_data = 16'h0000, ld_data, rsp_data, fl_dq_out, fl_dq_in;
   logic [4:0] cmd_count = 5'h01;
   logic [3:0] ld_offset = 4'h0;
   logic cmd_ready, ld_ready, rsp_valid, busy, suspended, fl_dq_oe;
   logic fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n;
   int err_total = 0, checks = 0;
   always #12.5 mclk = ~mclk;
   assign ld_data = 16'h1230 + 16'(ld_offset);
   always @(posedge mclk) if (ld_valid && ld_ready) ld_offset <= ld_offset + 4'h1;
   fbpes_ctrl DUT (.*);
   fbpes_flash_model FLASH (.*);
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic issue(fbpes_op_t op, logic [21:0] a, logic [15:0] d, logic [4:0] n);
      int i;
      @(negedge mclk);
      {cmd_op, cmd_addr, cmd_data, cmd_count, cmd_valid} = {op, a, d, n, 1'b1};
      for (i = 0; i < 5000 && cmd_ready !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 1'b0;
      if (i == 5000) chk("take timeout", 16'h0001, 16'h0000);
      if (i == 5000) results();
   endtask
   task automatic rsp(fbpes_rsp_t e);
      int i;
      for (i = 0; i < 5000 && rsp_valid !== 1'b1; i++) @(negedge mclk);
      chk("status", 16'(e), i < 5000 ? 16'(rsp_status) : 16'hdead);
      if (i == 5000) results();
   endtask
   task automatic run(fbpes_op_t op, logic [21:0] a, logic [15:0] d, logic [4:0] n, fbpes_rsp_t e);
      issue(op, a, d, n);
      rsp(e);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst = 0;
      chk("ready", 16'h0001, 16'(cmd_ready));
      run(OP_PROG, 22'h000005, 16'h00f0, 5'h01, RSP_OK);
      run(OP_PROG, 22'h000005, 16'h0030, 5'h01, RSP_OK);
      run(OP_READ, 22'h000005, 16'h0000, 5'h01, RSP_OK);
      chk("reprogram", 16'h00f0 & 16'h0030, rsp_data);
      $display("test program done");
      run(OP_BUF, 22'h000020, 16'h0000, 5'h11, RSP_REFUSED);
      run(OP_BUF, 22'h000020, 16'h0000, 5'h00, RSP_REFUSED);
      ld_valid = 1'b1;
      run(OP_BUF, 22'h000020, 16'h0000, 5'h10, RSP_OK);
      ld_valid = 1'b0;
      run(OP_READ, 22'h00002f, 16'h0000, 5'h01, RSP_OK);
      chk("last word", 16'h123f, rsp_data);
      $display("test buffer done");
      run(OP_SUSPEND, 22'h008000, 16'h0000, 5'h01, RSP_REFUSED);
      issue(OP_SERASE, 22'h008000, 16'h0000, 5'h01);
      issue(OP_SUSPEND, 22'h008000, 16'h0000, 5'h01);
      rsp(RSP_OK);
      chk("suspended", 16'h0001, 16'(suspended));
      run(OP_RESUME, 22'h008000, 16'h0000, 5'h01, RSP_OK);
      chk("resumed", 16'h0000, 16'(suspended));
      $display("test erase suspend done");
      run(OP_PROG, 22'h000003, 16'h0012, 5'h01, RSP_OK);
      run(OP_CERASE, 22'h000000, 16'h0000, 5'h01, RSP_OK);
      run(OP_READ, 22'h000003, 16'h0000, 5'h01, RSP_OK);
      chk("erased", 16'hffff, rsp_data);
      run(OP_HWRESET, 22'h000000, 16'h0000, 5'h01, RSP_OK);
      $display("test chip erase and reset done");
      results();
   end
endmodule
